// ### mxd_pkg.sv
package mxd_pkg;
	// ********************************
	// datapath shape
	// ********************************
	localparam int W  = 16;               // operand word width
	localparam int RW = 4;                // register number width
	localparam int PW = 3;                // processor number width

	// ********************************
	// microinstruction codes
	// ********************************
	typedef enum logic [4:0] {
		OP_NOP, OP_BRF_RD, OP_BRF_WR, OP_G1_RD, OP_G1_WR,
		OP_G2_RD, OP_G2_WR, OP_G3_RD, OP_G3_WR, OP_SUM,
		OP_CMP, OP_SKIP, OP_BSENSE, OP_SHIFT, OP_MS_RD,
		OP_MS_WR, OP_FRJ, OP_FNJ, OP_CONST, OP_BP
	} mxd_op_e;

	// alu fan-in source select
	localparam logic [1:0] FI_A   = 2'h0;
	localparam logic [1:0] FI_B   = 2'h1;
	localparam logic [1:0] FI_D   = 2'h2;
	localparam logic [1:0] FI_SUM = 2'h3;

	// constant generator selects and values
	localparam logic [2:0] CK_M1   = 3'h0;
	localparam logic [2:0] CK_ZERO = 3'h1;
	localparam logic [2:0] CK_P1   = 3'h2;
	localparam logic [2:0] CK_3    = 3'h3;
	localparam logic [2:0] CK_D    = 3'h4;
	localparam logic [2:0] CK_WORD = 3'h5;
	localparam logic [2:0] CK_BYTE = 3'h6;
	localparam logic [2:0] CK_NIB  = 3'h7;
	localparam logic [W-1:0] KV_3    = 16'h0003;
	localparam logic [W-1:0] KV_D    = 16'h000D;
	localparam logic [W-1:0] KV_WORD = 16'h0010;
	localparam logic [W-1:0] KV_BYTE = 16'h0008;
	localparam logic [W-1:0] KV_NIB  = 16'h0004;

	// register/register function codes
	localparam logic [7:0] FN_RR_LO = 8'h20;
	localparam logic [7:0] FN_RR_HI = 8'h29;

	// format jump table bases
	localparam logic [W-1:0] AT_RR_BASE  = 16'h0400;
	localparam logic [W-1:0] AT_OTH_BASE = 16'h0800;
	localparam logic [W-1:0] AT_STRIDE   = 16'h0040;

	// ********************************
	// software register port map
	// ********************************
	localparam logic [3:0] RA_CTRL = 4'h0;
	localparam logic [3:0] RA_STAT = 4'h4;
	localparam logic [3:0] RA_A    = 4'h8;
	localparam logic [3:0] RA_B    = 4'hC;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam int CTRL_LSB_FIRST = 0;    // scan from bit 0 upward
	localparam int CTRL_NO_FC     = 1;    // ignore forced carry
	localparam int ST_CMP_LO  = 0;        // gt,eq,lt at 0..2
	localparam int ST_SKIP    = 3;
	localparam int ST_FOUND   = 4;
	localparam int ST_BUSY    = 5;
	localparam int ST_FC      = 6;
endpackage

// ### mxd_scan.sv
`timescale 1ns/100ps
// bit-sense scan and double-word shifter, purely combinational
module mxd_scan
	import mxd_pkg::*;
(
	input  wire logic [W-1:0]  a_in,      // operand scanned
	input  wire logic          want,      // bit value sought
	input  wire logic          lsb_first, // scan direction
	input  wire logic [W-1:0]  abuf,      // high shift buffer
	input  wire logic [W-1:0]  bbuf,      // low shift buffer
	input  wire logic [3:0]    shamt,     // shift amount
	output logic               found,     // scan hit
	output logic [W-1:0]       cnt,       // positions without a find
	output logic [W-1:0]       hit_mask,  // one-hot of found bit
	output logic [W-1:0]       sh_a,      // shifted high word
	output logic [W-1:0]       sh_b       // shifted low word
);
	logic [2*W-1:0] pair;                 // concatenated shift pair

	// ********************************
	// scan: position 0 is the msb, or bit 0 (the lsb) when lsb_first is set
	// ********************************
	always_comb begin
		found    = 1'b0;
		cnt      = '0;
		hit_mask = '0;
		for (int i = 0; i < W; i++) begin
			// position i counted from the chosen end
			if (!found && a_in[lsb_first ? i : W-1-i] == want) begin
				found = 1'b1;
				cnt   = W'(i);
				hit_mask[lsb_first ? i : W-1-i] = 1'b1;
			end
		end
	end

	// ********************************
	// shifter: logical left over both buffers
	// ********************************
	always_comb begin
		pair = {abuf, bbuf} << shamt;
		sh_a = pair[2*W-1:W];
		sh_b = pair[W-1:0];
	end
endmodule

// ### mxd_exec.sv
`timescale 1ns/100ps
// How it works
// RULE1 - basic write: processor plus register, fan-in data
// RULE2 - group I read returns buffered start, instruction
// RULE3 - group I read data enabled into A or B
// RULE4 - start write loads pending buffer, written back first
// RULE5 - instruction write loads buffer, backup written second
// RULE6 - group II file read and write
// RULE7 - group III registers live in I/O adapters
// RULE8 - sum adds A and B onto fan-in
// RULE9 - compare makes status bits, stored in register
// RULE10 - skip tests conditions including A equals zero
// RULE11 - bit sense adds miss count to B
// RULE12 - shift through two buffers, back into A, B
// RULE13 - storage address loaded from A, then presented
// RULE14 - storage read feeds pointer logic and A
// RULE15 - storage write data via data register
// RULE16 - fetch, format, function sequences chained
// RULE17 - format jump classifies by type and mode
// RULE18 - codes 20 to 29 pick ten functions
// RULE19 - format address from table plus instruction buffer
// RULE20 - function address from instruction and microinstruction
// RULE21 - constant generator feeds B
// RULE22 - late blockpoint writes back the backup start
// RULE23 - untargeted registers keep their contents
module mxd_exec
	import mxd_pkg::*;
#(
	parameter int NPROC = 8,              // processor states
	parameter int NREG  = 16              // registers per file
)(
	input  wire logic          SYS_CLK,
	input  wire logic          SRST,
	input  wire logic          UOP_VALID,  // microinstruction present
	input  wire mxd_op_e       UOP_CODE,
	input  wire logic [RW-1:0] UOP_REG,    // register number
	input  wire logic [1:0]    UOP_SEL,    // fan-in / target select
	input  wire logic [3:0]    UOP_AUX,    // modifier field
	input  wire logic [W-1:0]  UOP_ADDR,   // address of this op
	input  wire logic [PW-1:0] PROC_NUM,   // current processor
	input  wire logic [PW-1:0] WB_PROC,    // write-back processor
	input  wire logic          WB_START,   // first write-back cycle
	input  wire logic          WB_INSTR,   // second write-back cycle
	input  wire logic          BP_LAST,    // blockpoint in last cycle
	input  wire logic [W-1:0]  MS_RDATA,
	input  wire logic          MS_RVALID,
	input  wire logic [W-1:0]  IO_RDATA,   // adapter register data
	input  wire logic [3:0]    REG_ADDR,
	input  wire logic [W-1:0]  REG_WDATA,
	input  wire logic          REG_WR,
	input  wire logic          REG_RD,
	output logic [W-1:0]       REG_RDATA,
	output logic [W-1:0]       MS_ADDR,
	output logic [W-1:0]       MS_WDATA,
	output logic               MS_RD,
	output logic               MS_WR,
	output logic [W-1:0]       IO_WDATA,
	output logic [RW-1:0]      IO_REG,
	output logic [1:0]         IO_PROC,
	output logic               IO_WR,
	output logic [W-1:0]       UADDR,      // microaddress register
	output logic               SKIP_NEXT,
	output logic               BUSY
);
	typedef enum logic [1:0] {ST_RUN, ST_SHIFT, ST_MSRD} mxd_st_e;

	// ********************************
	// storage
	// ********************************
	logic [W-1:0] brf_mem [NPROC*NREG];   // basic file
	logic [W-1:0] erf2_mem [NPROC*NREG];  // group II file
	logic [W-1:0] pmu_mem [NPROC];        // stored start addresses
	logic [W-1:0] frf_mem [NPROC];        // saved instructions

	mxd_st_e      st_ff;                  // sequencing state
	logic [W-1:0] a_ff, b_ff, d_ff;       // operand and data regs
	logic [W-1:0] nxt_a, nxt_b;
	logic [W-1:0] abuf_ff, bbuf_ff;       // shift buffers
	logic [3:0]   shamt_ff;
	logic [W-1:0] smu_ff;                 // microaddress register
	logic [W-1:0] pp_ff, pb_ff;           // pending / backup start
	logic [W-1:0] f_ff, fb_ff;            // instruction + backup
	logic [2:0]   at_ptr_ff;              // table pointer
	logic         fc_ff;                  // forced carry
	logic [2:0]   cmp_ff;                 // lt, eq, gt
	logic         found_ff;
	logic [1:0]   ctrl_ff;                // software control

	logic         go;                     // op accepted this cycle
	logic [PW+RW-1:0] fidx;               // file index
	logic [W-1:0] sum, fanin, rd_val, konst, at_word;
	logic         rd_en, skip_cond;
	logic         sc_found;
	logic [W-1:0] sc_cnt, sc_mask, sh_a, sh_b;
	logic [7:0]   fcode;                  // function code field

	assign go    = UOP_VALID && st_ff == ST_RUN;
	// needs power-of-two NPROC and NREG
	assign fidx  = {PROC_NUM, UOP_REG};
	assign fcode = f_ff[W-1:W-8];

	// ********************************
	// format jump pointer and table
	// ********************************
	// pointer: class bit, then two addressing mode bits
	function automatic logic [2:0] at_ptr(input logic [W-1:0] ins);
		logic rr;
		rr = ins[W-1:W-8] >= FN_RR_LO && ins[W-1:W-8] <= FN_RR_HI;
		return {rr, ins[1:0]};  // RULE17
	endfunction

	// four entries serve register/register, one per mode
	function automatic logic [W-1:0] at_entry(input logic [2:0] p);
		logic [W-1:0] base;
		base = p[2] ? AT_RR_BASE : AT_OTH_BASE;
		return W'(base + AT_STRIDE * W'(p[1:0]));  // RULE17
	endfunction

	// entry at the pointer latched by the last fetch
	assign at_word = at_entry(at_ptr_ff);

	mxd_scan u_scan (
		.a_in      (a_ff),
		.want      (UOP_SEL[1]),
		.lsb_first (ctrl_ff[CTRL_LSB_FIRST]),
		.abuf      (abuf_ff),
		.bbuf      (bbuf_ff),
		.shamt     (shamt_ff),
		.found     (sc_found),
		.cnt       (sc_cnt),
		.hit_mask  (sc_mask),
		.sh_a      (sh_a),
		.sh_b      (sh_b)
	);

	// ********************************
	// alu fan-in and constants
	// ********************************
	// sum, fan-in selection and constant generator
	always_comb begin
		sum = W'(a_ff + b_ff + W'(fc_ff && !ctrl_ff[CTRL_NO_FC]));  // RULE8
		case (UOP_SEL)
			FI_A:    fanin = a_ff;
			FI_B:    fanin = b_ff;
			FI_D:    fanin = d_ff;
			default: fanin = sum;
		endcase
		case (UOP_AUX[2:0])
			CK_M1:   konst = '1;           // RULE21
			CK_ZERO: konst = '0;
			CK_P1:   konst = '0;           // +1 comes via forced carry
			CK_3:    konst = KV_3;
			CK_D:    konst = KV_D;
			CK_WORD: konst = KV_WORD;
			CK_BYTE: konst = KV_BYTE;
			default: konst = KV_NIB;
		endcase
	end

	// register file and buffer reads feeding the operand fan-in
	always_comb begin
		rd_en  = go;
		rd_val = '0;
		case (UOP_CODE)
			OP_BRF_RD: rd_val = brf_mem[fidx];
			// buffered copies, never the stored state
			OP_G1_RD:  rd_val = UOP_AUX[0] ? f_ff :
				{smu_ff[W-1:W-2], pp_ff[W-3:0]};  // RULE2
			OP_G2_RD:  rd_val = erf2_mem[fidx];  // RULE6
			OP_G3_RD:  rd_val = IO_RDATA;         // RULE7
			default:   rd_en  = 1'b0;
		endcase
	end

	// skip condition evaluation
	always_comb begin
		case (UOP_AUX[1:0])
			2'h0:    skip_cond = a_ff == '0;  // RULE10
			2'h1:    skip_cond = a_ff != '0;
			2'h2:    skip_cond = cmp_ff[1];
			default: skip_cond = cmp_ff[2];
		endcase
	end

	// ********************************
	// operand registers
	// ********************************
	// next A and B; anything not targeted holds
	always_comb begin
		nxt_a = a_ff;  // RULE23
		nxt_b = b_ff;
		if (rd_en) begin
			// read enables: sel bit 0 picks B
			if (UOP_SEL[0]) nxt_b = rd_val;  // RULE3
			else nxt_a = rd_val;
		end else if (go) begin
			case (UOP_CODE)
				OP_SUM:    nxt_a = sum;  // RULE8
				OP_BSENSE: begin
					if (sc_found) begin
						nxt_b = W'(b_ff + sc_cnt);  // RULE11
						if (UOP_AUX[0]) nxt_a = a_ff ^ sc_mask;
					end
				end
				OP_CONST:  nxt_b = konst;  // RULE21
				default:   nxt_b = b_ff;
			endcase
		end else if (st_ff == ST_SHIFT) begin
			nxt_a = sh_a;  // RULE12
			nxt_b = sh_b;
		end else if (st_ff == ST_MSRD && MS_RVALID) begin
			nxt_a = MS_RDATA;  // RULE14
		end else if (REG_WR && REG_ADDR == RA_A) begin
			// software load of A, lost if any op is accepted, a shift ends or storage answers
			nxt_a = REG_WDATA;
		end
	end

	// operand register update
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			a_ff <= '0;
			b_ff <= '0;
		end else begin
			a_ff <= nxt_a;
			b_ff <= nxt_b;
		end
	end

	// ********************************
	// sequencing: shift and storage read
	// ********************************
	// shift takes one extra cycle, storage read waits for data
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			st_ff    <= ST_RUN;
			BUSY     <= 1'b0;
			abuf_ff  <= '0;
			bbuf_ff  <= '0;
			shamt_ff <= '0;
		end else begin
			case (st_ff)
				ST_RUN: begin
					if (go && UOP_CODE == OP_SHIFT) begin
						abuf_ff  <= a_ff;  // RULE12
						bbuf_ff  <= b_ff;
						shamt_ff <= UOP_AUX;
						st_ff    <= ST_SHIFT;
						BUSY     <= 1'b1;
					end else if (go && UOP_CODE == OP_MS_RD) begin
						st_ff <= ST_MSRD;
						BUSY  <= 1'b1;
					end
				end
				ST_SHIFT: begin
					st_ff <= ST_RUN;
					BUSY  <= 1'b0;
				end
				ST_MSRD: begin
					// no timeout: storage always answers
					if (MS_RVALID) begin
						st_ff <= ST_RUN;
						BUSY  <= 1'b0;
					end
				end
				default: begin
					st_ff <= ST_RUN;
					BUSY  <= 1'b0;
				end
			endcase
		end
	end

	// ********************************
	// main storage port
	// ********************************
	// address from A fan-in, write data via data register
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			MS_ADDR   <= '0;
			MS_WDATA  <= '0;
			MS_RD     <= 1'b0;
			MS_WR     <= 1'b0;
			d_ff      <= '0;
			at_ptr_ff <= '0;
		end else begin
			MS_RD <= go && UOP_CODE == OP_MS_RD;
			MS_WR <= go && UOP_CODE == OP_MS_WR;
			if (go && (UOP_CODE == OP_MS_RD || UOP_CODE == OP_MS_WR))
				MS_ADDR <= a_ff;  // RULE13
			if (go && UOP_CODE == OP_MS_WR) begin
				d_ff     <= b_ff;  // RULE15
				MS_WDATA <= b_ff;
			end
			// fetched word also feeds the table pointer
			if (st_ff == ST_MSRD && MS_RVALID)
				at_ptr_ff <= at_ptr(MS_RDATA);  // RULE14
		end
	end

	// ********************************
	// group III adapter port
	// ********************************
	// adapter decodes reads itself; writes leave from fan-in
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			IO_WR    <= 1'b0;
			IO_WDATA <= '0;
			IO_REG   <= '0;
			IO_PROC  <= '0;
		end else begin
			IO_WR <= go && UOP_CODE == OP_G3_WR;
			if (go && UOP_CODE == OP_G3_WR) begin
				IO_WDATA <= fanin;  // RULE7
				IO_REG   <= UOP_REG;
				IO_PROC  <= UOP_AUX[1:0];
			end
		end
	end

	// ********************************
	// group I buffers and branch formation
	// ********************************
	// start address buffers, instruction buffers, jumps
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			smu_ff <= '0;
			pp_ff  <= '0;
			pb_ff  <= '0;
			f_ff   <= '0;
			fb_ff  <= '0;
		end else if (go) begin
			case (UOP_CODE)
				OP_G1_WR: begin
					if (UOP_AUX[0]) begin
						f_ff  <= fanin;  // RULE5
						fb_ff <= fanin;
					end else begin
						smu_ff <= fanin;  // RULE4
						pp_ff  <= fanin;
					end
				end
				OP_BP: begin
					// late blockpoint: next start already in smu
					pb_ff <= W'(UOP_ADDR + 1'b1);
					if (!BP_LAST) pp_ff <= W'(UOP_ADDR + 1'b1);
				end
				OP_FRJ: begin  // RULE16
					// table entry merged with instruction low nibble
					pp_ff <= {at_word[W-1:4], f_ff[3:0]};  // RULE19
				end
				OP_FNJ: begin
					// codes 20..29 give ten entries 0..9
					if (UOP_SEL[0])
						smu_ff <= {UOP_AUX, UOP_REG, 4'h0,
							fcode[3:0]};  // RULE20
					if (UOP_SEL[1])
						pp_ff <= {UOP_AUX, UOP_REG, 4'h0,
							fcode[3:0]};  // RULE18
				end
				default: smu_ff <= smu_ff;  // RULE23
			endcase
		end
	end

	// ********************************
	// register files and write-back
	// ********************************
	// file writes; write-back runs beside execution
	always_ff @(posedge SYS_CLK) begin
		if (go && UOP_CODE == OP_BRF_WR)
			brf_mem[fidx] <= fanin;  // RULE1
		if (go && UOP_CODE == OP_CMP)
			brf_mem[fidx] <= {{(W-3){1'b0}}, a_ff < b_ff,
				a_ff == b_ff, a_ff > b_ff};  // RULE9
		if (go && UOP_CODE == OP_G2_WR)
			erf2_mem[fidx] <= fanin;  // RULE6
		if (WB_START)
			pmu_mem[WB_PROC] <= BP_LAST ? pb_ff : pp_ff;  // RULE22
		if (WB_INSTR)
			frf_mem[WB_PROC] <= fb_ff;  // RULE5
	end

	// ********************************
	// status flags
	// ********************************
	// compare bits, skip pulse, scan and forced carry
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			cmp_ff    <= '0;
			SKIP_NEXT <= 1'b0;
			found_ff  <= 1'b0;
			fc_ff     <= 1'b0;
		end else begin
			SKIP_NEXT <= go && UOP_CODE == OP_SKIP && skip_cond;  // RULE10
			if (go && UOP_CODE == OP_CMP)
				cmp_ff <= {a_ff < b_ff, a_ff == b_ff, a_ff > b_ff};
			if (go && UOP_CODE == OP_BSENSE)
				found_ff <= sc_found;
			if (go && UOP_CODE == OP_CONST)
				fc_ff <= UOP_AUX[2:0] == CK_P1;  // RULE21
		end
	end

	// ********************************
	// software register port
	// ********************************
	// control write, read data one cycle later
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			ctrl_ff   <= CTRL_RST;
			REG_RDATA <= '0;
		end else begin
			if (REG_WR && REG_ADDR == RA_CTRL)
				ctrl_ff <= REG_WDATA[1:0];
			REG_RDATA <= '0;
			if (REG_RD) begin
				case (REG_ADDR)
					RA_CTRL: REG_RDATA <= {{(W-2){1'b0}}, ctrl_ff};
					RA_STAT: REG_RDATA <= {{(W-7){1'b0}}, fc_ff,
						BUSY, found_ff, SKIP_NEXT, cmp_ff};
					RA_A:    REG_RDATA <= a_ff;
					RA_B:    REG_RDATA <= b_ff;
					default: REG_RDATA <= '0;  // unmapped
				endcase
			end
		end
	end

	assign UADDR = smu_ff;

	// ********************************
	// assertions
	// ********************************
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (SRST);

	a_skip_azero: assert property (go && UOP_CODE == OP_SKIP && // RULE10
		UOP_AUX[1:0] == 2'h0 && a_ff == '0 |=> SKIP_NEXT)
		else $error("skip on zero A missed");
	a_ms_addr: assert property (go && UOP_CODE == OP_MS_RD // RULE13
		|=> MS_RD && MS_ADDR == $past(a_ff) ##1 !MS_RD)
		else $error("storage address not from A");
	a_ms_wdata: assert property (go && UOP_CODE == OP_MS_WR // RULE15
		|=> MS_WR && MS_WDATA == $past(b_ff) && d_ff == MS_WDATA)
		else $error("storage write data wrong");
	a_shift_len: assert property (go && UOP_CODE == OP_SHIFT // RULE12
		|=> BUSY ##1 !BUSY)
		else $error("shift not two cycles");
	a_sum_value: assert property (go && UOP_CODE == OP_SUM // RULE8
		|=> a_ff == $past(sum))
		else $error("sum not loaded");
	a_wb_start: assert property (WB_START && !BP_LAST // RULE4
		|=> pmu_mem[$past(WB_PROC)] == $past(pp_ff))
		else $error("pending start not written back");
	a_wb_late: assert property (WB_START && BP_LAST // RULE22
		|=> pmu_mem[$past(WB_PROC)] == $past(pb_ff))
		else $error("backup start not written back");
	a_wb_instr: assert property (WB_INSTR // RULE5
		|=> frf_mem[$past(WB_PROC)] == $past(fb_ff))
		else $error("instruction backup not written back");
	a_const_three: assert property (go && UOP_CODE == OP_CONST && // RULE21
		UOP_AUX[2:0] == CK_3 |=> b_ff == KV_3 && !fc_ff)
		else $error("constant three not in B");
	a_hold_ab: assert property (!UOP_VALID && st_ff == ST_RUN // RULE23
		&& !(REG_WR && REG_ADDR == RA_A)
		|=> $stable(a_ff) && $stable(b_ff))
		else $error("operands changed while idle");
	a_g1_read: assert property (go && UOP_CODE == OP_G1_RD && // RULE2
		!UOP_AUX[0] && !UOP_SEL[0] |=> a_ff ==
		{$past(smu_ff[W-1:W-2]), $past(pp_ff[W-3:0])})
		else $error("group one read not buffered");

	c_shift: cover property (go && UOP_CODE == OP_SHIFT ##2 !BUSY);
	c_ms_read: cover property (MS_RD ##[1:8] MS_RVALID);
	c_bsense: cover property (go && UOP_CODE == OP_BSENSE && sc_found);
	c_late_bp: cover property (WB_START && BP_LAST);
endmodule

// ### mxd_far_model.sv
`timescale 1ns/100ps
// ****
// main storage and i/o adapter stand-in
// ****
module mxd_far_model
	import mxd_pkg::*;
(
	input  wire logic          SYS_CLK,
	input  wire logic          SLOW,      // long storage latency
	input  wire logic          MS_RD,
	input  wire logic          MS_WR,
	input  wire logic [W-1:0]  MS_ADDR,
	input  wire logic [W-1:0]  MS_WDATA,
	output logic [W-1:0]       MS_RDATA,
	output logic               MS_RVALID,
	input  wire logic          IO_WR,
	input  wire logic [W-1:0]  IO_WDATA,
	input  wire logic [RW-1:0] IO_REG,
	input  wire logic [1:0]    IO_PROC,
	input  wire logic [RW-1:0] UOP_REG,   // register a read selects
	input  wire logic [3:0]    UOP_AUX,   // adapter of a read
	output logic [W-1:0]       IO_RDATA
);
	logic [W-1:0] mem_ff [0:255];   // storage, low address bits only
	logic [W-1:0] ioreg_ff [0:63];  // one set per i/o processor
	logic [W-1:0] last_ff = '0;     // last word returned
	logic [W-1:0] rad_ff = '0;      // read address held
	int           wait_ff = 0;      // cycles to the answer
	// storage: strobes are pulses, address taken with them
	always_ff @(posedge SYS_CLK) begin
		MS_RVALID <= 1'h0;
		if (MS_WR) begin
			mem_ff[MS_ADDR[7:0]] <= MS_WDATA;
		end
		if (MS_RD) begin
			rad_ff <= MS_ADDR;
			wait_ff <= SLOW ? 4 : 1;
		end else if (wait_ff == 1) begin
			MS_RVALID <= 1'h1;
			last_ff <= mem_ff[rad_ff[7:0]];
			wait_ff <= 0;
		end else if (wait_ff > 1) begin
			wait_ff <= wait_ff - 1;
		end
	end
	// outside the answer cycle the bus shows no stale word
	assign MS_RDATA = MS_RVALID ? last_ff : ~last_ff;
	// adapter registers: written from fan-in, read in the op cycle
	always_ff @(posedge SYS_CLK) begin
		if (IO_WR) begin
			ioreg_ff[{IO_PROC, IO_REG}] <= IO_WDATA;
		end
	end
	assign IO_RDATA = ioreg_ff[{UOP_AUX[1:0], UOP_REG}];
endmodule

// ### testbench.sv
`timescale 1ns/100ps
module testbench
	import mxd_pkg::*;
;
	// ****
	// stimulus and observed signals
	// ****
	logic          SYS_CLK = 1'h0;
	logic          SRST = 1'h1;
	logic          UOP_VALID = 1'h0;
	mxd_op_e       UOP_CODE = OP_NOP;
	logic [RW-1:0] UOP_REG = '0;
	logic [1:0]    UOP_SEL = '0;
	logic [3:0]    UOP_AUX = '0;
	logic [W-1:0]  UOP_ADDR = '0;     // tied
	logic [PW-1:0] PROC_NUM = '0;
	logic [PW-1:0] WB_PROC = '0;      // tied
	logic          WB_START = 1'h0;
	logic          WB_INSTR = 1'h0;
	logic          BP_LAST = 1'h0;
	logic [3:0]    REG_ADDR = '0;
	logic [W-1:0]  REG_WDATA = '0;
	logic          REG_WR = 1'h0;
	logic          REG_RD = 1'h0;
	logic          SLOW = 1'h0;       // storage latency choice
	logic [W-1:0]  MS_RDATA, IO_RDATA, REG_RDATA, MS_ADDR, MS_WDATA;
	logic [W-1:0]  IO_WDATA, UADDR, v;
	logic [RW-1:0] IO_REG;
	logic [1:0]    IO_PROC;
	logic          MS_RVALID, MS_RD, MS_WR, IO_WR, SKIP_NEXT, BUSY;
	logic [33:0]   snap_ms;           // storage strobes in cycle one
	logic [22:0]   snap_io;           // adapter strobe in cycle one
	mxd_op_e       wc, rc;
	int            miscompares = 0;
	int            n_tests = 0;
	// constant generator values, in select order
	logic [W-1:0]  kv [8] = '{16'hFFFF, 16'h0000, 16'h0000, KV_3,
		KV_D, KV_WORD, KV_BYTE, KV_NIB};
	logic [W-1:0]  cm [3] = '{16'h0001, 16'h0002, 16'h0004};

	mxd_exec u_dut (.SYS_CLK, .SRST, .UOP_VALID, .UOP_CODE, .UOP_REG,
		.UOP_SEL, .UOP_AUX, .UOP_ADDR, .PROC_NUM, .WB_PROC, .WB_START,
		.WB_INSTR, .BP_LAST, .MS_RDATA, .MS_RVALID, .IO_RDATA, .REG_ADDR,
		.REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .MS_ADDR, .MS_WDATA,
		.MS_RD, .MS_WR, .IO_WDATA, .IO_REG, .IO_PROC, .IO_WR, .UADDR,
		.SKIP_NEXT, .BUSY);
	mxd_far_model u_far (.SYS_CLK, .SLOW, .MS_RD, .MS_WR, .MS_ADDR,
		.MS_WDATA, .MS_RDATA, .MS_RVALID, .IO_WR, .IO_WDATA, .IO_REG,
		.IO_PROC, .UOP_REG, .UOP_AUX, .IO_RDATA);

	always #4 SYS_CLK = ~SYS_CLK;

	// ****
	// shared tasks
	// ****
	task automatic chk(input logic [39:0] g, input logic [39:0] e,
		input string m);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: %s got %h", $time, m, g);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// one microinstruction; snapshot strobes, wait out busy
	task automatic uop(input mxd_op_e c, input logic [3:0] r,
		input logic [1:0] s, input logic [3:0] x);
		int n;
		@(posedge SYS_CLK);
		UOP_VALID <= 1'h1;
		UOP_CODE <= c;
		UOP_REG <= r;
		UOP_SEL <= s;
		UOP_AUX <= x;
		@(posedge SYS_CLK);
		UOP_VALID <= 1'h0;
		#1;
		snap_ms = {MS_RD, MS_WR, MS_ADDR, MS_WDATA};
		snap_io = {IO_WR, IO_PROC, IO_REG, IO_WDATA};
		n = 0;
		while (BUSY !== 1'h0 && n < 50) begin
			@(posedge SYS_CLK);
			#1;
			n++;
		end
		chk(40'(BUSY), 40'h0, "busy stuck");
	endtask
	task automatic wr(input logic [3:0] a, input logic [W-1:0] d);
		@(posedge SYS_CLK);
		REG_WR <= 1'h1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge SYS_CLK);
		REG_WR <= 1'h0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge SYS_CLK);
		REG_RD <= 1'h1;
		REG_ADDR <= a;
		@(posedge SYS_CLK);
		REG_RD <= 1'h0;
		#1;
		v = REG_RDATA;
	endtask
	// b has no write path: route the value through a group two file
	task automatic setab(input logic [W-1:0] a, input logic [W-1:0] b);
		wr(RA_A, b);
		uop(OP_G2_WR, 4'hF, FI_A, 4'h0);
		uop(OP_G2_RD, 4'hF, 2'h1, 4'h0);
		wr(RA_A, a);
	endtask

	// ****
	// test sequence
	// ****
	initial begin
		repeat (2) @(posedge SYS_CLK);
		SRST <= 1'h0;
		rd(RA_STAT);
		chk(v, 16'h0000, "stat reset");
		for (int i = 0; i < 8; i++) begin
			uop(OP_CONST, 4'h0, 2'h0, 4'(i));
			rd(RA_B);
			chk(v, kv[i], "const");
		end
		// plus one rides on the forced carry
		wr(RA_A, 16'h1234);
		uop(OP_CONST, 4'h0, 2'h0, 4'(CK_P1));
		uop(OP_SUM, 4'h0, FI_SUM, 4'h0);
		rd(RA_A);
		chk(v, 16'h1235, "sum carry");
		uop(OP_CONST, 4'h0, 2'h0, 4'(CK_3));
		uop(OP_SUM, 4'h0, FI_SUM, 4'h0);
		rd(RA_A);
		chk(v, 16'h1238, "sum");
		// same register number, two processors, both files
		for (int k = 0; k < 2; k++) begin
			wc = k ? OP_G2_WR : OP_BRF_WR;
			rc = k ? OP_G2_RD : OP_BRF_RD;
			for (int p = 1; p < 3; p++) begin
				PROC_NUM <= 3'(p);
				wr(RA_A, 16'(16'h1100 * p + k));
				uop(wc, 4'h5, FI_A, 4'h0);
			end
			wr(RA_A, 16'h0000);
			PROC_NUM <= 3'h1;
			uop(rc, 4'h5, 2'h1, 4'h0);
			rd(RA_B);
			chk(v, 16'(16'h1100 + k), "file read");
			rd(RA_A);
			chk(v, 16'h0000, "a kept");
		end
		// greater, equal, less
		for (int i = 0; i < 3; i++) begin
			setab(16'h0050, 16'(16'h004F + i));
			uop(OP_CMP, 4'h7, 2'h0, 4'h0);
			rd(RA_STAT);
			chk(v & 16'h0007, cm[i], "cmp stat");
			uop(OP_BRF_RD, 4'h7, 2'h0, 4'h0);
			rd(RA_A);
			chk(v, cm[i], "cmp stored");
		end
		// storage write, then read back fast and slow
		setab(16'h0012, 16'hBEEF);
		uop(OP_MS_WR, 4'h0, 2'h0, 4'h0);
		chk(snap_ms, {2'h1, 16'h0012, 16'hBEEF}, "ms wr");
		for (int s = 0; s < 2; s++) begin
			SLOW <= s[0];
			wr(RA_A, 16'h0012);
			uop(OP_MS_RD, 4'h0, 2'h0, 4'h0);
			chk(snap_ms[33:16], {2'h2, 16'h0012}, "ms rd");
			rd(RA_A);
			chk(v, 16'hBEEF, "ms data");
		end
		// adapter register out and back
		setab(16'h0A5C, 16'h0000);
		uop(OP_G3_WR, 4'h3, FI_A, 4'h2);
		chk(snap_io, {3'h6, 4'h3, 16'h0A5C}, "io wr");
		uop(OP_G3_RD, 4'h3, 2'h1, 4'h2);
		rd(RA_B);
		chk(v, 16'h0A5C, "io rd");
		// scan from the top, toggle on: seven misses
		setab(16'h0100, 16'h0003);
		uop(OP_BSENSE, 4'h0, 2'h2, 4'h1);
		rd(RA_B);
		chk(v, 16'h000A, "sense count");
		rd(RA_A);
		chk(v, 16'h0000, "sense toggle");
		uop(OP_SKIP, 4'h0, 2'h0, 4'h0);
		chk(SKIP_NEXT, 1'h1, "skip");
		rd(RA_STAT);
		chk(v & 16'h0010, 16'h0010, "found");
		// scan from the bottom, no toggle: eight misses
		wr(RA_CTRL, 16'h0001);
		setab(16'h0100, 16'h0000);
		uop(OP_BSENSE, 4'h0, 2'h2, 4'h0);
		rd(RA_B);
		chk(v, 16'h0008, "sense lsb");
		rd(RA_A);
		chk(v, 16'h0100, "no toggle");
		uop(OP_SKIP, 4'h0, 2'h0, 4'h0);
		chk(SKIP_NEXT, 1'h0, "no skip");
		// pair {0100,0008} moved four places left
		uop(OP_SHIFT, 4'h0, 2'h0, 4'h4);
		rd(RA_A);
		chk(v, 16'h1000, "shift a");
		rd(RA_B);
		chk(v, 16'h0080, "shift b");
		wr(RA_CTRL, 16'h0000);
		// instruction buffer, function jump, pending start
		wr(RA_A, 16'h2503);
		uop(OP_G1_WR, 4'h0, FI_A, 4'h1);
		uop(OP_G1_RD, 4'h0, 2'h1, 4'h1);
		rd(RA_B);
		chk(v, 16'h2503, "instr buf");
		uop(OP_FNJ, 4'h3, 2'h1, 4'hA);
		chk(UADDR, 16'hA305, "fnj addr");
		// last fetch was BEEF: other class, mode 3, nibble 3
		uop(OP_FRJ, 4'h0, 2'h0, 4'h0);
		uop(OP_G1_RD, 4'h0, 2'h0, 4'h0);
		rd(RA_A);
		chk(v & 16'h3FFF, 16'h08C3, "frj addr");
		wr(RA_A, 16'h1ABC);
		uop(OP_G1_WR, 4'h0, FI_A, 4'h0);
		uop(OP_G1_RD, 4'h0, 2'h1, 4'h0);
		rd(RA_B);
		chk(v & 16'h3FFF, 16'h1ABC, "start buf");
		// late blockpoint fills only the backup; write back both ways
		BP_LAST <= 1'h1;
		uop(OP_BP, 4'h0, 2'h0, 4'h0);
		for (int j = 0; j < 2; j++) begin
			@(posedge SYS_CLK);
			{BP_LAST, WB_START} <= {j[0], 1'h1};
			@(posedge SYS_CLK);
			{WB_START, WB_INSTR} <= 2'h1;
			@(posedge SYS_CLK);
			WB_INSTR <= 1'h0;
		end
		results;
	end

	// watchdog: the sequence needs well under 3000 cycles
	initial begin
		#200000;
		miscompares++;
		results;
	end
endmodule
